// File: dv/chan_filter_asserts.sv
// Port checker for the channel filter and half-band stage
module chan_filter_asserts (
  input logic                       mclk,
  input logic                       rst_n,
  input logic                       inValid,
  input chan_filter_pkg::iq20_t     inData,
  input logic                       inReady,
  input chan_filter_pkg::chan_cfg_t chanCfg,
  input chan_filter_pkg::coef_cmd_t coefCmd,
  input chan_filter_pkg::coef_t     coefRdData,
  input logic                       outValid,
  input chan_filter_pkg::iq22_t     outData,
  input logic                       outReady
);
  timeunit 1ns;
  timeprecision 1ps;
  import chan_filter_pkg::*;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  AST_RESET_QUIET:
    assert property (disable iff (1'b0) !rst_n |=> !inReady && !outValid && outData == '0 && coefRdData == '0)
    else $error("outputs not quiet after reset");
  AST_READY_AFTER_RESET:
    assert property ($rose(rst_n) |=> inReady)
    else $error("input not ready after reset release");
  AST_OUT_HOLD:
    assert property (outValid && !outReady |=> outValid && $stable(outData))
    else $error("output word dropped or changed while stalled");
  AST_HB_OFF_ALIGNED:
    assert property (outValid && !chanCfg.halfbandEnable |-> outData.i[1:0] == 2'h0 && outData.q[1:0] == 2'h0)
    else $error("half-band off output not a padded channel word");
  AST_BYPASS_DROP:
    assert property (chanCfg.bypass && inValid && inReady |=> !inReady)
    else $error("bypass sample not handed on");
  AST_DECIM_ONE:
    assert property (!chanCfg.bypass && chanCfg.decimRate == 4'h0 && chanCfg.decimPhase == 4'h0
                     && inValid && inReady |=> !inReady)
    else $error("rate one sample did not start a computation");
  AST_PHASE_NEVER:
    assert property (!chanCfg.bypass && chanCfg.decimPhase > chanCfg.decimRate && inValid && inReady |=> inReady)
    else $error("computation started on an unused phase");
  AST_COEF_SINGLE:
    assert property (coefCmd.write && coefCmd.startAddr == coefCmd.stopAddr && $stable(coefCmd.startAddr)
                     ##1 (!coefCmd.write && !coefCmd.read && $stable(coefCmd.startAddr)) [*3]
                     |-> coefRdData == $past(coefCmd.wrData, 3))
    else $error("single location write not read back");
  AST_COEF_STABLE:
    assert property ((!coefCmd.write && !coefCmd.read && $stable(coefCmd.startAddr)
                      && $stable(coefCmd.stopAddr)) [*4] |-> $stable(coefRdData))
    else $error("coefficient pointer moved without an access");
endmodule : chan_filter_asserts

bind channel_fir_interp_halfband chan_filter_asserts i_chan_filter_asserts (
  .mclk, .rst_n, .inValid, .inData, .inReady, .chanCfg, .coefCmd, .coefRdData, .outValid, .outData, .outReady
);

// File: dv/channel_fir_interp_halfband_bench.sv
// Self-checking bench for the channel filter and half-band stage
module channel_fir_interp_halfband_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import chan_filter_pkg::*;

  logic      mclk    = 1'b0;
  logic      rst_n   = 1'b0;
  logic      inValid = 1'b0;
  iq20_t     inData  = '0;
  chan_cfg_t chanCfg = '0;
  coef_cmd_t coefCmd = '0;
  logic      stall   = 1'b0;
  logic      inReady;
  logic      outValid;
  logic      outReady;
  coef_t     coefRdData;
  iq22_t     outData;
  iq22_t     expQ[$];
  longint    xi[$], xq[$], bi[$], bq[$];
  longint    h[0:127];
  int        num_errors = 0;
  int        compares   = 0;
  int        cycles     = 0;
  int        cnt;
  bit [31:0] seed = 32'hCAC5FFDF;
  // taps, rate-1, phase, scale, symmetric, bypass, half-band, slow sink
  int        t[6][8] = '{'{4, 0, 0, 3, 0, 0, 1, 0}, '{4, 2, 1, 0, 0, 0, 0, 1}, '{6, 1, 1, 2, 1, 0, 1, 0},
                         '{1, 0, 0, 0, 0, 1, 1, 1}, '{4, 1, 3, 1, 0, 0, 0, 0}, '{5, 0, 0, 1, 0, 0, 0, 0}};

  channel_fir_interp_halfband i_channel_fir_interp_halfband (
    .mclk, .rst_n, .inValid, .inData, .inReady, .chanCfg, .coefCmd, .coefRdData, .outValid, .outData, .outReady
  );
  router_sink_model i_router_sink_model (.mclk, .rst_n, .stall, .outReady);

  always #5 mclk = ~mclk;

  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic longint sat(longint v, longint m);
    return v > m ? m : (v < -m - 1 ? -m - 1 : v);
  endfunction : sat

  function automatic longint hb_odd(longint b[$]);
    return sat((14 * (b[0] + b[5]) - 66 * (b[1] + b[4]) + 309 * (b[2] + b[3]) + 256) >>> 9, 64'sh1FFFFF);
  endfunction : hb_odd

  task automatic check(input logic [43:0] seen, input logic [43:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic note(longint vi, longint vq);
    iq22_t e;
    e.i = samp22_t'(vi);
    e.q = samp22_t'(vq);
    expQ.push_back(e);
  endtask : note

  task automatic chan_out(longint vi, longint vq);
    if (chanCfg.halfbandEnable)
    begin
      bi.push_front(4 * vi);
      bq.push_front(4 * vq);
      void'(bi.pop_back());
      void'(bq.pop_back());
      note(bi[3], bq[3]);
      note(hb_odd(bi), hb_odd(bq));
    end
    else
      note(4 * vi, 4 * vq);
  endtask : chan_out

  task automatic send(iq20_t s);
    longint ai, aq;
    inValid <= 1'b1;
    inData  <= s;
    do @(posedge mclk); while (inReady !== 1'b1);
    xi.push_front(s.i);
    xq.push_front(s.q);
    void'(xi.pop_back());
    void'(xq.pop_back());
    if (chanCfg.bypass)
      chan_out(s.i, s.q);
    else
    begin
      if (cnt == chanCfg.decimPhase)
      begin
        ai = 0;
        aq = 0;
        for (int k = 0; k <= chanCfg.tapCount; k++)
        begin
          ai += h[k] * xi[k];
          aq += h[k] * xq[k];
        end
        chan_out(sat(ai >>> (22 - chanCfg.scaleCode), 64'sh7FFFF), sat(aq >>> (22 - chanCfg.scaleCode), 64'sh7FFFF));
        // Offset moves mid-computation; the running sample must keep its set
        chanCfg.coefOffset <= chanCfg.coefOffset ^ 6'h20;
        @(posedge mclk);
        chanCfg.coefOffset <= chanCfg.coefOffset ^ 6'h20;
      end
      cnt = (cnt == chanCfg.decimRate) ? 0 : cnt + 1;
    end
    // Idle gaps keep the half-band input rate down
    if (rnd() % 4 == 0)
    begin
      inValid <= 1'b0;
      @(posedge mclk);
    end
  endtask : send

  task automatic pulse(bit rd, longint d);
    coefCmd.read   <= rd;
    coefCmd.write  <= !rd;
    coefCmd.wrData <= coef_t'(d);
    @(posedge mclk);
    coefCmd.read   <= 1'b0;
    coefCmd.write  <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : pulse

  task automatic load(int n, bit sym);
    int        m;
    bit [31:0] r;
    m = sym ? n / 2 : 0;
    for (int k = 0; k < n; k++)
    begin
      r = rnd();
      h[k] = $signed(r[17:0]);
    end
    for (int k = 0; k < m; k++)
      h[k] = h[n-1-k];
    coefCmd.startAddr <= 6'(sym ? 64 - m : 0);
    coefCmd.stopAddr  <= 6'(sym ? m - 1 : n - 1);
    repeat (2) @(posedge mclk);
    // Whole 20-bit words: byte pairing is done ahead of this port
    for (int k = 0; k < n - m; k++)
    begin
      coefCmd.write  <= 1'b1;
      coefCmd.wrData <= coef_t'(sym ? h[m+k] : h[n-1-k]);
      @(posedge mclk);
    end
    coefCmd.write <= 1'b0;
  endtask : load

  task automatic report_and_stop();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      report_and_stop();
    end
    if (rst_n === 1'b1 && outValid === 1'b1 && outReady === 1'b1)
    begin
      if (expQ.size() == 0)
        check(outData, ~outData);
      else if (chanCfg.halfbandEnable)
        check(outData, expQ.pop_front());
      else
        check(outData, expQ.pop_front());
    end
  end

  initial
  begin
    bit [31:0] r;
    for (int c = 0; c < 6; c++)
    begin
      stall   <= t[c][7][0];
      chanCfg <= '{tapCount: 7'(t[c][0] - 1), decimRate: 4'(t[c][1]), decimPhase: 4'(t[c][2]),
                   scaleCode: 2'(t[c][3]), symmetric: t[c][4][0], bypass: t[c][5][0],
                   coefOffset: 6'(t[c][4] != 0 ? 64 - t[c][0] / 2 : 0), halfbandEnable: t[c][6][0]};
      rst_n   <= 1'b0;
      repeat (c == 0 ? 12 : 2) @(posedge mclk);
      rst_n   <= 1'b1;
      xi = {};
      xq = {};
      bi = {0, 0, 0, 0, 0, 0};
      bq = {0, 0, 0, 0, 0, 0};
      repeat (128) xi.push_back(0);
      repeat (128) xq.push_back(0);
      cnt = 0;
      repeat (3) @(posedge mclk);
      load(t[c][0], t[c][4][0]);
      if (c == 0)
      begin
        for (int a = 0; a < 4; a++)
        begin
          repeat (4) @(posedge mclk);
          check(44'(coefRdData), 44'(coef_t'(h[3-a])));
          pulse(1'b1, 0);
        end
        coefCmd.startAddr <= 6'h3F;
        coefCmd.stopAddr  <= 6'h3F;
        repeat (2) @(posedge mclk);
        pulse(1'b0, 64'h2ABCD);
        pulse(1'b0, 64'h5A5A5);
        check(44'(coefRdData), 44'h5A5A5);
        pulse(1'b1, 0);
        check(44'(coefRdData), 44'h5A5A5);
      end
      for (int s = 0; s < 24; s++)
      begin
        r = rnd();
        send({r[19:0], r[31:12]});
      end
      inValid <= 1'b0;
      for (int w = 0; w < 8000 && expQ.size() > 0; w++)
        @(posedge mclk);
      repeat (30) @(posedge mclk);
      check(44'(expQ.size()), 44'h0);
    end
    report_and_stop();
  end
endmodule : channel_fir_interp_halfband_bench

// File: dv/router_sink_model.sv
// Output router stand-in that takes samples promptly or slowly
module router_sink_model (
  input  logic mclk,
  input  logic rst_n,
  input  logic stall,
  output logic outReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] tick;

  always_ff @(posedge mclk)
  begin
    tick     <= rst_n ? tick + 6'h01 : 6'h00;
    // Slow mode takes 4 of 64 cycles so the FIFO backs up
    outReady <= rst_n && (!stall || tick[5:2] == 4'h0);
  end
endmodule : router_sink_model

// File: hw/chan_filter_pkg.sv
// Constants and carrier types for the channel filter and interpolating half-band stage
package chan_filter_pkg;

  localparam int SAMPLE_W   = 20;
  localparam int HB_W       = 22;
  localparam int COEF_W     = 20;
  localparam int ACC_W      = 48;
  localparam int HB_ACC_W   = 38;
  localparam int COEF_DEPTH = 64;
  localparam int COEF_AW    = 6;
  localparam int HIST_DEPTH = 128;
  localparam int HIST_AW    = 7;
  localparam int FIFO_DEPTH = 16;

  // Coefficients are signed fractions, 1.0 at 2^19
  localparam int COEF_FRAC = 19;
  localparam logic [1:0] SCALE_NONE = 2'h3;

  localparam logic signed [ACC_W-1:0] CH_MAX = 48'sh0000_0007_FFFF;
  localparam logic signed [ACC_W-1:0] CH_MIN = 48'shFFFF_FFF8_0000;

  localparam logic signed [11:0] HB_C1 = 12'sh00E;
  localparam logic signed [11:0] HB_C3 = 12'shFBE;
  localparam logic signed [11:0] HB_C5 = 12'sh135;
  localparam logic signed [11:0] HB_C6 = 12'sh200;
  localparam int HB_SHIFT = 9;
  localparam logic signed [HB_ACC_W-1:0] HB_ROUND = 38'sh00_0000_0100;
  localparam logic signed [HB_ACC_W-1:0] HB_MAX   = 38'sh00_001F_FFFF;
  localparam logic signed [HB_ACC_W-1:0] HB_MIN   = 38'sh3F_FFE0_0000;
  localparam logic [1:0] HB_PEND_EVEN = 2'h2;
  localparam logic [1:0] HB_PEND_ODD  = 2'h1;

  typedef logic signed [SAMPLE_W-1:0] samp20_t;
  typedef logic signed [HB_W-1:0]     samp22_t;
  typedef logic signed [COEF_W-1:0]   coef_t;

  typedef struct packed {
    samp20_t i;
    samp20_t q;
  } iq20_t;

  typedef struct packed {
    samp22_t i;
    samp22_t q;
  } iq22_t;

  typedef struct packed {
    logic [6:0]         tapCount;
    logic [3:0]         decimRate;
    logic [3:0]         decimPhase;
    logic [1:0]         scaleCode;
    logic               symmetric;
    logic               bypass;
    logic [COEF_AW-1:0] coefOffset;
    logic               halfbandEnable;
  } chan_cfg_t;

  typedef struct packed {
    logic [COEF_AW-1:0] startAddr;
    logic [COEF_AW-1:0] stopAddr;
    logic               write;
    logic               read;
    coef_t              wrData;
  } coef_cmd_t;

  typedef enum logic [1:0] {FIR_IDLE, FIR_RUN, FIR_DRAIN, FIR_FINISH} fir_phase_t;

endpackage : chan_filter_pkg

// File: hw/channel_fir_interp_halfband.sv
// Channel coefficient filter followed by the interpolate-by-2 half-band stage
module channel_fir_interp_halfband (
  input  logic                       mclk,
  input  logic                       rst_n,
  input  logic                       inValid,
  input  chan_filter_pkg::iq20_t     inData,
  output logic                       inReady,
  input  chan_filter_pkg::chan_cfg_t chanCfg,
  input  chan_filter_pkg::coef_cmd_t coefCmd,
  output chan_filter_pkg::coef_t     coefRdData,
  output logic                       outValid,
  output chan_filter_pkg::iq22_t     outData,
  input  logic                       outReady
);
  import chan_filter_pkg::*;

  typedef struct packed {
    fir_phase_t         phase;
    logic               inReady;
    logic [HIST_AW-1:0] histWr;
    logic [HIST_AW-1:0] newest;
    logic [3:0]         decimCnt;
    logic [6:0]         k;
    logic               macValid;
    logic [6:0]         taps;
    logic               symm;
    logic [1:0]         scale;
    logic [COEF_AW-1:0] offset;
    logic signed [ACC_W-1:0] accI;
    logic signed [ACC_W-1:0] accQ;
    logic               chValid;
    iq20_t              chData;
    iq22_t [5:0]        hbLine;
    logic [1:0]         hbPend;
    logic               hbPass;
    logic [COEF_AW-1:0] coefPtr;
    logic [COEF_AW-1:0] lastStart;
    coef_t              coefRd;
    logic               outValid;
    iq22_t              outData;
  } state_t;

  state_t             s;
  state_t             next_s;
  logic               accept;
  logic [HIST_AW-1:0] histAddr;
  logic [COEF_AW-1:0] coefAddr;
  logic [7:0]         tap_count;
  logic [7:0]         mirrorTap;
  logic [7:0]         farTap;
  iq20_t              histRd;
  coef_t              coefRdA;
  coef_t              coefRdB;
  logic signed [2*SAMPLE_W-1:0] prodI;
  logic signed [2*SAMPLE_W-1:0] prodQ;
  iq22_t              hbWord;
  logic               fifoWrReady;
  logic               fifoRdValid;
  logic               fifoRdReady;
  iq22_t              fifoRdData;

  // Saturate a shifted accumulator to the 20-bit channel output
  function automatic samp20_t satChan(input logic signed [ACC_W-1:0] v);
    samp20_t r;
    if (v > CH_MAX)
      r = CH_MAX[SAMPLE_W-1:0];
    else if (v < CH_MIN)
      r = CH_MIN[SAMPLE_W-1:0];
    else
      r = v[SAMPLE_W-1:0];
    return r;
  endfunction : satChan

  // Arithmetic shift by 22..19 for codes 00..11, then saturate
  function automatic samp20_t scaleChan(input logic signed [ACC_W-1:0] acc, input logic [1:0] code);
    logic [5:0] shamt;
    shamt = 6'(COEF_FRAC) + 6'(SCALE_NONE - code);
    return satChan(acc >>> shamt);
  endfunction : scaleChan

  // Round half up at the output weight, then saturate to 22 bits
  function automatic samp22_t roundHb(input logic signed [HB_ACC_W-1:0] sum);
    logic signed [HB_ACC_W-1:0] v;
    samp22_t r;
    v = (sum + HB_ROUND) >>> HB_SHIFT;
    if (v > HB_MAX)
      r = HB_MAX[HB_W-1:0];
    else if (v < HB_MIN)
      r = HB_MIN[HB_W-1:0];
    else
      r = v[HB_W-1:0];
    return r;
  endfunction : roundHb

  // Odd output phase: the six non-zero outer taps, folded in pairs
  function automatic samp22_t hbOdd(input samp22_t x0, input samp22_t x1, input samp22_t x2,
                                    input samp22_t x3, input samp22_t x4, input samp22_t x5);
    logic signed [HB_ACC_W-1:0] a;
    logic signed [HB_ACC_W-1:0] b;
    logic signed [HB_ACC_W-1:0] c;
    a = HB_ACC_W'(x0) + HB_ACC_W'(x5);
    b = HB_ACC_W'(x1) + HB_ACC_W'(x4);
    c = HB_ACC_W'(x2) + HB_ACC_W'(x3);
    return roundHb(a * HB_ACC_W'(HB_C1) + b * HB_ACC_W'(HB_C3) + c * HB_ACC_W'(HB_C5));
  endfunction : hbOdd

  // Even output phase: centre tap only
  function automatic samp22_t hbEven(input samp22_t x3);
    return roundHb(HB_ACC_W'(x3) * HB_ACC_W'(HB_C6));
  endfunction : hbEven

  assign accept   = s.inReady && inValid;
  assign histAddr = s.newest - s.k;

  // Tap k meets sample delayed by k; address follows the load order
  always_comb
  begin
    tap_count     = {1'b0, s.taps} + 8'h01;
    mirrorTap = {1'b0, s.taps} - {1'b0, s.k};
    farTap    = (mirrorTap > {1'b0, s.k}) ? mirrorTap : {1'b0, s.k};
    if (s.symm)
      coefAddr = s.offset + COEF_AW'(farTap - (tap_count >> 1));
    else
      coefAddr = s.offset + s.taps[COEF_AW-1:0] - s.k[COEF_AW-1:0];
  end

  assign prodI = histRd.i * coefRdA;
  assign prodQ = histRd.q * coefRdA;

  always_comb
  begin
    if (s.hbPass)
      hbWord = s.hbLine[0];
    else if (s.hbPend == HB_PEND_EVEN)
    begin
      hbWord.i = hbEven(s.hbLine[3].i);
      hbWord.q = hbEven(s.hbLine[3].q);
    end
    else
    begin
      hbWord.i = hbOdd(s.hbLine[0].i, s.hbLine[1].i, s.hbLine[2].i,
                       s.hbLine[3].i, s.hbLine[4].i, s.hbLine[5].i);
      hbWord.q = hbOdd(s.hbLine[0].q, s.hbLine[1].q, s.hbLine[2].q,
                       s.hbLine[3].q, s.hbLine[4].q, s.hbLine[5].q);
    end
  end

  assign fifoRdReady = !s.outValid || outReady;

  always_comb
  begin
    next_s = s;

    // Coefficient port: a new start address reloads the pointer
    if (coefCmd.startAddr != s.lastStart)
    begin
      next_s.coefPtr   = coefCmd.startAddr;
      next_s.lastStart = coefCmd.startAddr;
    end
    else if (coefCmd.write || coefCmd.read)
    begin
      if (s.coefPtr == coefCmd.stopAddr)
        next_s.coefPtr = coefCmd.startAddr;
      else
        next_s.coefPtr = s.coefPtr + COEF_AW'(1);
    end
    next_s.coefRd = coefRdB;

    // Half-band stage: two outputs per input when enabled, even phase first; one passed through when off
    if (s.hbPend != 2'h0 && fifoWrReady)
      next_s.hbPend = s.hbPend - 2'h1;
    if (s.chValid && s.hbPend == 2'h0)
    begin
      next_s.chValid = 1'b0;
      next_s.hbLine  = {s.hbLine[4:0], {s.chData.i, 2'b00}, {s.chData.q, 2'b00}};
      next_s.hbPend  = chanCfg.halfbandEnable ? HB_PEND_EVEN : HB_PEND_ODD;
      next_s.hbPass  = !chanCfg.halfbandEnable;
    end

    // Multiply-accumulate on data read one cycle earlier
    next_s.macValid = 1'b0;
    if (s.macValid)
    begin
      next_s.accI = s.accI + ACC_W'(prodI);
      next_s.accQ = s.accQ + ACC_W'(prodQ);
    end

    case (s.phase)
      FIR_IDLE:
      begin
        if (accept)
        begin
          next_s.histWr = s.histWr + HIST_AW'(1);
          if (chanCfg.bypass)
          begin
            next_s.chValid = 1'b1;
            next_s.chData  = inData;
          end
          else
          begin
            next_s.decimCnt = (s.decimCnt == chanCfg.decimRate) ? 4'h0 : s.decimCnt + 4'h1;
            if (s.decimCnt == chanCfg.decimPhase)
            begin
              next_s.phase  = FIR_RUN;
              next_s.newest = s.histWr;
              next_s.k      = 7'h00;
              next_s.accI   = '0;
              next_s.accQ   = '0;
              next_s.taps   = chanCfg.tapCount;
              next_s.symm   = chanCfg.symmetric;
              next_s.scale  = chanCfg.scaleCode;
              next_s.offset = chanCfg.coefOffset;
            end
          end
        end
      end
      FIR_RUN:
      begin
        next_s.macValid = 1'b1;
        if (s.k == s.taps)
          next_s.phase = FIR_DRAIN;
        else
          next_s.k = s.k + 7'h01;
      end
      FIR_DRAIN:
      begin
        next_s.phase = FIR_FINISH;
      end
      FIR_FINISH:
      begin
        // Waits for the half-band stage to take the previous result
        if (!s.chValid)
        begin
          next_s.chValid  = 1'b1;
          next_s.chData.i = scaleChan(s.accI, s.scale);
          next_s.chData.q = scaleChan(s.accQ, s.scale);
          next_s.phase    = FIR_IDLE;
        end
      end
      default:
      begin
        next_s.phase = FIR_IDLE;
      end
    endcase

    // Input is held off while computing or while a result waits
    next_s.inReady = (next_s.phase == FIR_IDLE) && !next_s.chValid;

    if (fifoRdReady)
    begin
      next_s.outValid = fifoRdValid;
      if (fifoRdValid)
        next_s.outData = fifoRdData;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s <= state_t'('0);
    end
    else
    begin
      s <= next_s;
    end
  end

  dual_read_ram #(
    .WIDTH (2*SAMPLE_W),
    .DEPTH (HIST_DEPTH)
  ) histRam (
    .clk     (mclk),
    .rst_n   (rst_n),
    .wrEn    (accept),
    .wrAddr  (s.histWr),
    .wrData  (inData),
    .rdAddrA (histAddr),
    .rdDataA (histRd),
    .rdAddrB (s.histWr),
    .rdDataB ()
  );

  // Several coefficient sets may sit here, chosen by the offset
  dual_read_ram #(
    .WIDTH (COEF_W),
    .DEPTH (COEF_DEPTH)
  ) coefRam (
    .clk     (mclk),
    .rst_n   (rst_n),
    .wrEn    (coefCmd.write),
    .wrAddr  (s.coefPtr),
    .wrData  (coefCmd.wrData),
    .rdAddrA (coefAddr),
    .rdDataA (coefRdA),
    .rdAddrB (s.coefPtr),
    .rdDataB (coefRdB)
  );

  sample_fifo #(
    .WIDTH (2*HB_W),
    .DEPTH (FIFO_DEPTH)
  ) outFifo (
    .clk     (mclk),
    .rst_n   (rst_n),
    .wrValid (s.hbPend != 2'h0),
    .wrReady (fifoWrReady),
    .wrData  (hbWord),
    .rdValid (fifoRdValid),
    .rdReady (fifoRdReady),
    .rdData  (fifoRdData)
  );

  assign inReady    = s.inReady;
  assign coefRdData = s.coefRd;
  assign outValid   = s.outValid;
  assign outData    = s.outData;

endmodule : channel_fir_interp_halfband

// File: hw/dual_read_ram.sv
// Small memory with one write port and two registered read ports
module dual_read_ram #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 64
) (
  input  logic                     clk,
  input  logic                     rst_n,
  input  logic                     wrEn,
  input  logic [$clog2(DEPTH)-1:0] wrAddr,
  input  logic [WIDTH-1:0]         wrData,
  input  logic [$clog2(DEPTH)-1:0] rdAddrA,
  output logic [WIDTH-1:0]         rdDataA,
  input  logic [$clog2(DEPTH)-1:0] rdAddrB,
  output logic [WIDTH-1:0]         rdDataB
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] cells;
    logic [WIDTH-1:0]            rdA;
    logic [WIDTH-1:0]            rdB;
  } ram_state_t;

  ram_state_t s;
  ram_state_t next_s;

  // Reads return the old word when written in the same cycle
  always_comb
  begin
    next_s = s;
    next_s.rdA = s.cells[rdAddrA];
    next_s.rdB = s.cells[rdAddrB];
    if (wrEn)
    begin
      next_s.cells[wrAddr] = wrData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rdDataA = s.rdA;
  assign rdDataB = s.rdB;

endmodule : dual_read_ram

// File: hw/sample_fifo.sv
// Output sample FIFO with valid/ready on both sides
module sample_fifo #(
  parameter int WIDTH = 44,
  parameter int DEPTH = 16
) (
  input  logic             clk,
  input  logic             rst_n,
  input  logic             wrValid,
  output logic             wrReady,
  input  logic [WIDTH-1:0] wrData,
  output logic             rdValid,
  input  logic             rdReady,
  output logic [WIDTH-1:0] rdData
);

  // DEPTH must be a power of two; the extra pointer bit tells full from empty
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] cells;
    logic [AW:0]                 wrPtr;
    logic [AW:0]                 rdPtr;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic        full;
  logic        empty;

  assign full    = (s.wrPtr[AW] != s.rdPtr[AW]) && (s.wrPtr[AW-1:0] == s.rdPtr[AW-1:0]);
  assign empty   = (s.wrPtr == s.rdPtr);
  assign wrReady = !full;
  assign rdValid = !empty;
  assign rdData  = s.cells[s.rdPtr[AW-1:0]];

  always_comb
  begin
    next_s = s;
    if (wrValid && !full)
    begin
      next_s.cells[s.wrPtr[AW-1:0]] = wrData;
      next_s.wrPtr = s.wrPtr + (AW+1)'(1);
    end
    if (rdReady && !empty)
    begin
      next_s.rdPtr = s.rdPtr + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule : sample_fifo
